/* File: logic/tpo_port.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tpo_consts.svh"
module tpo_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire tpo_pkg::tpo_addr_t addr_i,
  input wire tpo_pkg::tpo_byte_t wdata_i,
  input wire tpo_pkg::tpo_byte_t wmask_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output tpo_pkg::tpo_byte_t rdata_o,
  // Trigger events from the interrupt sources
  input wire logic timer1_match_event_i,
  input wire logic timer2_match_event_i,
  input wire logic ext_pin2_edge_event_i,
  // Shared port pins
  input wire tpo_pkg::tpo_byte_t pin_i,
  output tpo_pkg::tpo_byte_t pin_o,
  output tpo_pkg::tpo_byte_t pin_oe_o,
  // Trigger indication
  output logic [1:0] loaded_o
);
  import tpo_pkg::*;

  tpo_state_t st;
  tpo_state_t next_st;
  logic load_hi;
  logic load_lo;
  logic byte_mode;
  logic [1:0] loaded;
  tpo_byte_t buf_mask;
  tpo_byte_t trig_mask;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Bits under mask take the new value, the rest keep the old one
  function automatic tpo_byte_t merge(input tpo_byte_t old_v, input tpo_byte_t new_v,
                                      input tpo_byte_t mask);
    merge = (new_v & mask) | (old_v & ~mask);
  endfunction

  // ----------------------------------------
  // Trigger source selection
  // ----------------------------------------
  assign byte_mode = st.ctrl[`TPO_CTRL_BYTE_BIT];

  tpo_trig_sel u_trig_sel (
    .byte_mode_i(byte_mode),
    .external_trigger_select_i(st.ctrl[`TPO_CTRL_EXT_BIT]),
    .timer1_match_event_i(timer1_match_event_i),
    .timer2_match_event_i(timer2_match_event_i),
    .ext_pin2_edge_event_i(ext_pin2_edge_event_i),
    .load_hi_o(load_hi),
    .load_lo_o(load_lo)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    loaded = '0;
    loaded[`TPO_STAT_LO_BIT] = load_lo;
    loaded[`TPO_STAT_HI_BIT] = load_hi;
    // Pins come from outside the clock domain
    next_st.pin_meta = pin_i;
    next_st.pin_sync = st.pin_meta;

    // Buffer lanes: one nibble per address, both in byte mode
    if (byte_mode) begin
      buf_mask = `TPO_ALL;  // [R2]
    end else if (addr_i == `TPO_ADDR_BUF_HI) begin
      buf_mask = `TPO_NIB_HI;  // [R1]
    end else begin
      buf_mask = `TPO_NIB_LO;  // [R1]
    end

    if (wr_i) begin
      unique case (addr_i)
        `TPO_ADDR_BUF_LO, `TPO_ADDR_BUF_HI: begin
          next_st.out_buf = merge(st.out_buf, wdata_i, buf_mask & wmask_i);  // [R14]
        end
        `TPO_ADDR_DIR: begin
          next_st.dir = merge(st.dir, wdata_i, wmask_i);  // [R13]
        end
        `TPO_ADDR_MODE: begin
          next_st.mode_sel = merge(st.mode_sel, wdata_i, wmask_i);  // [R8] [R13]
        end
        `TPO_ADDR_CTRL: begin
          next_st.ctrl = merge(st.ctrl, wdata_i, wmask_i & `TPO_CTRL_USED);  // [R10] [R13]
        end
        `TPO_ADDR_LATCH: begin
          // Triggered bits belong to the hardware
          next_st.latch = merge(st.latch, wdata_i, wmask_i & ~st.mode_sel);  // [R9]
        end
        `TPO_ADDR_STAT: begin
          next_st.stat = st.stat & ~(wdata_i & wmask_i);
        end
        `TPO_ADDR_PINS: begin
          next_st.stat = next_st.stat;
        end
      endcase
    end

    // Output enable kept as its own flop so pins come straight from registers
    next_st.pin_oe = ~next_st.dir;

    // Trigger copy; the buffer must already hold the next pattern
    trig_mask = {{4{load_hi}}, {4{load_lo}}} & st.mode_sel;  // [R16] [R17] [R5]
    next_st.latch = merge(next_st.latch, st.out_buf, trig_mask);  // [R15]

    // Event flags: a load in the clearing cycle survives
    next_st.stat = next_st.stat | {6'h00, loaded};

    // Read data stands one cycle after the strobe, zero otherwise
    next_st.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        `TPO_ADDR_BUF_LO, `TPO_ADDR_BUF_HI: begin
          next_st.rdata = st.out_buf & st.mode_sel;  // [R3] [R4]
        end
        `TPO_ADDR_DIR: begin
          next_st.rdata = st.dir;
        end
        `TPO_ADDR_MODE: begin
          next_st.rdata = st.mode_sel;
        end
        `TPO_ADDR_CTRL: begin
          next_st.rdata = st.ctrl;
        end
        `TPO_ADDR_LATCH: begin
          next_st.rdata = st.latch;
        end
        `TPO_ADDR_PINS: begin
          // Output pins read back the latch, inputs the synchronised level
          next_st.rdata = (st.latch & ~st.dir) | (st.pin_sync & st.dir);
        end
        `TPO_ADDR_STAT: begin
          next_st.rdata = st.stat;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st.out_buf <= `TPO_BUF_RST;
      st.dir <= `TPO_DIR_RST;  // [R7]
      st.pin_oe <= ~`TPO_DIR_RST;
      st.mode_sel <= `TPO_MODE_RST;  // [R8]
      st.ctrl <= `TPO_CTRL_RST;  // [R10]
      st.latch <= `TPO_LATCH_RST;
      st.stat <= `TPO_STAT_RST;
      st.rdata <= 8'h00;
      st.pin_meta <= 8'h00;
      st.pin_sync <= 8'h00;
      loaded_o <= 2'h0;
    end else begin
      st <= next_st;
      loaded_o <= loaded;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Direction gates only the drive enable pin_oe_o; pin_o shows the latch on input pins too
  assign pin_o = st.latch;  // [R6]
  assign pin_oe_o = st.pin_oe;
  assign rdata_o = st.rdata;
endmodule
`default_nettype wire

/* File: shared/tpo_consts.svh */
// Notes on behaviour
// (R1) Nibble mode: low buffer write sets low nibble, high buffer write high nibble.
// (R2) Byte mode: a write to either buffer address loads all eight buffer bits.
// (R3) Buffer reads return high nibble over low nibble at either address.
// (R4) Buffer bits of pins in plain port mode read as zero.
// (R5) Software loads the next pattern before the next trigger event arrives.
// (R6) Pins used for triggered output need their direction bit cleared to output.
// (R7) Reset sets every direction bit to one, all pins input.
// (R8) Per-bit choice of plain or triggered mode; reset selects plain mode.
// (R9) Software writes to the output latch do not touch triggered-mode bits.
// (R10) Control register holds grouping and trigger source; resets to zero.
// (R11) Nibble mode triggers: timer2/timer1, or timer1/pin2 edge when external selected.
// (R12) Byte mode: all bits move on timer1, or pin2 edge when external selected.
// (R13) Direction, mode and control registers accept single-bit and full writes.
// (R14) Low and high buffers sit at addresses of their own.
// (R15) On a trigger the buffer is copied to the output latch that cycle.
// (R16) A trigger changes only latch bits in triggered mode.
// (R17) Low buffer nibble drives pins 0 to 3, high nibble pins 4 to 7.
`ifndef TPO_CONSTS_SVH
`define TPO_CONSTS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TPO_ADDR_BUF_LO 3'h0
`define TPO_ADDR_BUF_HI 3'h1
`define TPO_ADDR_DIR 3'h2
`define TPO_ADDR_MODE 3'h3
`define TPO_ADDR_CTRL 3'h4
`define TPO_ADDR_LATCH 3'h5
`define TPO_ADDR_PINS 3'h6
`define TPO_ADDR_STAT 3'h7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TPO_DIR_RST 8'hff
`define TPO_MODE_RST 8'h00
`define TPO_CTRL_RST 8'h00
`define TPO_BUF_RST 8'h00
`define TPO_LATCH_RST 8'h00
`define TPO_STAT_RST 8'h00

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define TPO_CTRL_EXT_BIT 0
`define TPO_CTRL_BYTE_BIT 1
`define TPO_CTRL_USED 8'h03
`define TPO_STAT_LO_BIT 0
`define TPO_STAT_HI_BIT 1
`define TPO_NIB_LO 8'h0f
`define TPO_NIB_HI 8'hf0
`define TPO_ALL 8'hff

`endif

/* File: shared/tpo_pkg.sv */
`default_nettype none
package tpo_pkg;

  typedef logic [2:0] tpo_addr_t;
  typedef logic [7:0] tpo_byte_t;

  // ----------------------------------------
  // State of the port block, all but the loaded_o flop
  // ----------------------------------------
  typedef struct packed {
    tpo_byte_t out_buf;
    tpo_byte_t dir;
    tpo_byte_t pin_oe;
    tpo_byte_t mode_sel;
    tpo_byte_t ctrl;
    tpo_byte_t latch;
    tpo_byte_t stat;
    tpo_byte_t rdata;
    tpo_byte_t pin_meta;
    tpo_byte_t pin_sync;
  } tpo_state_t;

endpackage
`default_nettype wire

/* File: logic/tpo_trig_sel.sv */
`timescale 1ns/10ps
`default_nettype none
module tpo_trig_sel (
  // Configuration
  input wire logic byte_mode_i,
  input wire logic external_trigger_select_i,
  // Events, one-cycle pulses on clk
  input wire logic timer1_match_event_i,
  input wire logic timer2_match_event_i,
  input wire logic ext_pin2_edge_event_i,
  // Nibble loads
  output logic load_hi_o,
  output logic load_lo_o
);
  logic byte_ev;

  always_comb begin
    byte_ev = external_trigger_select_i ? ext_pin2_edge_event_i : timer1_match_event_i;
    if (byte_mode_i) begin
      load_hi_o = byte_ev;  // [R12]
      load_lo_o = byte_ev;  // [R12]
    end else if (external_trigger_select_i) begin
      load_hi_o = timer1_match_event_i;  // [R11]
      load_lo_o = ext_pin2_edge_event_i;  // [R11]
    end else begin
      load_hi_o = timer2_match_event_i;  // [R11]
      load_lo_o = timer1_match_event_i;  // [R11]
    end
  end
endmodule
`default_nettype wire

/* File: sim/tpo_port_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module tpo_port_chk (
  // Bus
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire tpo_pkg::tpo_addr_t addr_i,
  input wire tpo_pkg::tpo_byte_t wdata_i,
  input wire tpo_pkg::tpo_byte_t wmask_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire tpo_pkg::tpo_byte_t rdata_o,
  // Events and pins
  input wire logic timer1_match_event_i,
  input wire logic timer2_match_event_i,
  input wire logic ext_pin2_edge_event_i,
  input wire tpo_pkg::tpo_byte_t pin_o,
  input wire tpo_pkg::tpo_byte_t pin_oe_o,
  input wire logic [1:0] loaded_o
);
  import tpo_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic dir_wr, lat_wr, any_ev;
  assign dir_wr = wr_i && addr_i == 3'h2;
  assign lat_wr = wr_i && addr_i == 3'h5;
  assign any_ev = timer1_match_event_i | timer2_match_event_i | ext_pin2_edge_event_i;
  a_oe_after_reset: assert property ($past(!rst_n_i) |-> pin_oe_o == 8'h00)
    else $error("drive enable set after reset");
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_rd_dir: assert property (rd_i && addr_i == 3'h2 |=> rdata_o == ~pin_oe_o)
    else $error("direction read mismatch");
  a_oe_single_bit: assert property (dir_wr && wmask_i == 8'h01 |=>
    pin_oe_o == {$past(pin_oe_o[7:1]), ~$past(wdata_i[0])}) else $error("bit write wrong");
  a_oe_hold: assert property ($past(rst_n_i) && !$past(dir_wr) |-> $stable(pin_oe_o))
    else $error("drive enable moved");
  a_pin_hold: assert property ($past(rst_n_i) && !$past(lat_wr) && !$past(any_ev)
    |-> $stable(pin_o)) else $error("pins moved without cause");
  a_lo_source: assert property (loaded_o[0] |->
    $past(timer1_match_event_i) || $past(ext_pin2_edge_event_i)) else $error("bad low load");
  a_t2_not_lo: assert property (timer2_match_event_i && !timer1_match_event_i
    && !ext_pin2_edge_event_i |=> !loaded_o[0]) else $error("timer2 loaded low");
  c_both: cover property (loaded_o == 2'b11);
  c_lo: cover property (loaded_o == 2'b01);
  c_hi: cover property (loaded_o == 2'b10);
endmodule
bind tpo_port tpo_port_chk i_chk (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wmask_i, .wr_i,
  .rd_i, .rdata_o, .timer1_match_event_i, .timer2_match_event_i, .ext_pin2_edge_event_i,
  .pin_o, .pin_oe_o, .loaded_o);
`default_nettype wire

/* File: sim/tpo_load_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tpo_load_model (
  // Board side of the pins
  input wire logic clk_i,
  input wire tpo_pkg::tpo_byte_t pin_o,
  input wire tpo_pkg::tpo_byte_t pin_oe_o,
  output var tpo_pkg::tpo_byte_t pin_i
);
  import tpo_pkg::*;
  tpo_byte_t noise = 8'h5a;
  // Floating pins toggle so a stale level is never mistaken for a drive
  always @(posedge clk_i) noise <= ~noise;
  assign pin_i = (pin_o & pin_oe_o) | (noise & ~pin_oe_o);
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tpo_pkg::*;
  logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, rd_d = 0;
  tpo_addr_t addr_i = 3'h0;
  tpo_byte_t wdata_i = 8'h00, wmask_i = 8'h00, rdata_o, pin_i, pin_o, pin_oe_o;
  tpo_byte_t bf, lat = 8'h00, m, v0, v1, ld;
  logic [2:0] ev = 3'h0;
  logic [1:0] loaded_o;
  tpo_byte_t qr[$], qp[$];
  int fails = 0, n_compared = 0;
  // Load mask per control value and event (timer1, timer2, pin2)
  tpo_byte_t ldt[4][3] = '{'{8'h0f, 8'hf0, 8'h00}, '{8'hf0, 8'h00, 8'h0f},
    '{8'hff, 8'h00, 8'h00}, '{8'h00, 8'h00, 8'hff}};
  initial forever #10 clk_i = ~clk_i;
  tpo_port i_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wmask_i, .wr_i, .rd_i, .rdata_o,
    .timer1_match_event_i(ev[0]), .timer2_match_event_i(ev[1]),
    .ext_pin2_edge_event_i(ev[2]), .pin_i, .pin_o, .pin_oe_o, .loaded_o);
  tpo_load_model i_load (.clk_i, .pin_o, .pin_oe_o, .pin_i);
  task automatic cmp_rd(tpo_byte_t got, tpo_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(tpo_byte_t got, tpo_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t pins %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge clk_i) begin
    rd_d <= rd_i;
    if (rd_d) cmp_rd(rdata_o, qr.pop_front());
    if (rst_n_i && loaded_o !== 2'b00) cmp_pin(pin_o, qp.pop_front());
  end
  task automatic wr(tpo_addr_t a, tpo_byte_t d, tpo_byte_t k);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    wmask_i <= k;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(tpo_addr_t a, tpo_byte_t exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    qr.push_back(exp);
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  task automatic fire(int e);
    @(posedge clk_i);
    ev <= 3'(1 << e);
    @(posedge clk_i);
    ev <= 3'h0;
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    close_out();
  end
  initial begin
    void'($urandom(32'h122c46e4));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(3'h2, 8'hff);
    rd(3'h3, 8'h00);
    rd(3'h0, 8'h00);
    wr(3'h4, 8'hff, 8'hff);
    rd(3'h4, 8'h03);
    wr(3'h2, 8'h00, 8'hff);
    wr(3'h2, 8'hff, 8'h01);
    rd(3'h2, 8'h01);
    wr(3'h2, 8'h00, 8'h01);
    $display("test reset_and_config done");
    for (int c = 0; c < 4; c++) begin
      m = 8'($urandom());
      wr(3'h4, 8'(c), 8'hff);
      wr(3'h3, m, 8'hff);
      for (int e = 0; e < 3; e++) begin
        v0 = 8'($urandom());
        v1 = 8'($urandom());
        wr(3'h5, v0, 8'hff);
        lat = (lat & m) | (v0 & ~m);
        rd(3'h5, lat);
        wr(3'h0, v0, 8'hff);
        wr(3'h1, v1, 8'hff);
        bf = c[1] ? v1 : {v1[7:4], v0[3:0]};
        rd(3'h0, bf & m);
        rd(3'h1, bf & m);
        ld = ldt[c][e] & m;
        lat = (lat & ~ld) | (bf & ld);
        if (ldt[c][e] != 8'h00) qp.push_back(lat);
        fire(e);
        rd(3'h5, lat);
        rd(3'h6, lat);
        rd(3'h7, {6'h00, |ldt[c][e][7:4], |ldt[c][e][3:0]});
        wr(3'h7, 8'hff, 8'hff);
      end
      $display("test trigger control %0d done", c);
    end
    close_out();
  end
endmodule
`default_nettype wire
